// ---- logic/spl_pkg.sv ----
// Constants shared by the sync processor and line-lock supervisor.
// Assumes one 200 MHz system clock and a synchronous active-low reset.
package spl_pkg;

  // Sync priority codes written by the controller.
  localparam logic [1:0] PRIO_GREEN = 2'h0;
  localparam logic [1:0] PRIO_COMPOSITE = 2'h1;
  localparam logic [1:0] PRIO_SEPARATE = 2'h3;

  // Forced line frequency requests.
  localparam logic [1:0] FORCE_NONE = 2'h0;
  localparam logic [1:0] FORCE_2X = 2'h1;
  localparam logic [1:0] FORCE_3X = 2'h2;

  // Duty ratios as numerator and denominator.
  localparam int H_DUTY_NUM = 1;
  localparam int H_DUTY_DEN = 4;
  localparam int VEXT_NUM = 7;
  localparam int VEXT_DEN = 20;
  localparam int EQ_GAP_NUM = 3;
  localparam int EQ_GAP_DEN = 4;

  // Filtered lock level, full scale 8 V mapped to 256 steps.
  localparam logic [7:0] LOCK_HI = 8'hd0;
  localparam logic [7:0] LOCK_LO = 8'hc0;
  localparam logic [7:0] LVL_STEP_DN = 8'h10;
  localparam logic [7:0] LVL_RST = 8'h00;

  // Free-run code 0 is 0.8 times nominal, the top code 1.3 times.
  localparam int FREE_W = 5;
  localparam logic [4:0] FREE_RUN_RST = 5'h1f;
  // Phase code: centre is no shift, the ends are plus and minus T/10.
  localparam int PHASE_W = 5;
  localparam logic [4:0] PHASE_RST = 5'h10;

  // Status byte bit positions.
  localparam int ST_HLOCK = 7;
  localparam int ST_VLOCK = 6;
  localparam int ST_XRAY = 5;
  localparam int ST_HPOL = 4;
  localparam int ST_VPOL = 3;
  localparam int ST_VEXT = 2;
  localparam int ST_HDET = 1;
  localparam int ST_VDET = 0;
  localparam logic [7:0] STATUS_RST = 8'hc0;

  typedef enum logic {LK_UNLOCKED, LK_LOCKED} spl_lock_t;

endpackage

// ---- logic/spl_sync2.sv ----
// Two-stage synchroniser for asynchronous levels.
// Assumes the inputs are slow levels compared with the clock.
module spl_sync2 #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      meta_r <= '0;
      q <= '0;
    end
    else
    begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule

// ---- logic/spl_top.sv ----
// Sync processor and first line loop supervisor of a monitor deflection controller.
// Assumes an I2C decoder on the same clock drives the control ports and reads status_byte.
//
// Functional notes
// - Controller picks priority from detection flags
// - Accept separate, composite TTL or green sync
// - Line output follows mode and polarity table
// - Vertical output keeps source polarity
// - Lock pin low when locked
// - Line lock, vertical lock, X-ray readable
// - X-ray latch clears only by reset
// - Detect and report sync polarities
// - Line pulse valid below 25% duty
// - Extract vertical above 25%, at 35%
// - Drop equalizing pulses before phase comparator
// - Extracted vertical disconnects charge pump
// - External inhibit input disconnects charge pump
// - High pump current when locked
// - Free-run adjustable, reset selects 1.3x
// - Forced 2x/3x opens loop, holds filter
// - Phase reference shift of plus/minus T/10
// - Lock detector uses two-threshold hysteresis
// - One status byte holds all flags
module spl_top
  import spl_pkg::*;
#(
  parameter int CNT_W = 16
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic line_or_composite_input,
  input wire logic vsync_in,
  input wire logic green_sync_in,
  input wire logic line_loop_inhibit_input,
  input wire logic xray_in,
  input wire logic vert_lock_in,
  input wire logic phase_ref_pulse,
  input wire logic [1:0] sync_priority,
  input wire logic det_refresh,
  input wire logic xray_reset,
  input wire logic [1:0] force_mode,
  input wire logic free_run_wr,
  input wire logic [FREE_W-1:0] free_run_code,
  input wire logic phase_wr,
  input wire logic [PHASE_W-1:0] phase_code,
  output logic line_sync_out,
  output logic vsync_out,
  output logic line_lock_n_out,
  output logic internal_line_pulse,
  output logic pump_connect,
  output logic pump_high_current,
  output logic [1:0] filter_force,
  output logic [FREE_W-1:0] free_run_frequency,
  output logic [PHASE_W-1:0] phase_shift,
  output logic [7:0] status_byte
);

  if (CNT_W < 12 || CNT_W > 24)
  begin : g_chk
    $error("CNT_W must lie between 12 and 24");
  end

  localparam logic [CNT_W-1:0] CNT_MAX = '1;
  // A gap of at least twice the learnt period means pulses went missing.
  localparam int MISS_NUM = 2;
  localparam int MISS_DEN = 1;

  // Saturating up/down step of a signed balance counter.
  function automatic logic signed [CNT_W-1:0] bal_step(input logic signed [CNT_W-1:0] b, input logic up);
    logic signed [CNT_W-1:0] r;
    logic signed [CNT_W-1:0] one;
    r = b;
    one = CNT_W'(1);
    if (up && b != $signed({1'b0, {(CNT_W-1){1'b1}}}))
      r = b + one;
    else if (!up && b != $signed({1'b1, {(CNT_W-1){1'b0}}}))
      r = b - one;
    return r;
  endfunction

  // True when a*den >= b*num; the operands are widened so nothing is lost.
  function automatic logic ge_frac(input logic [CNT_W-1:0] a, input logic [CNT_W-1:0] b, input int num,
                                   input int den);
    logic [CNT_W+5:0] lhs;
    logic [CNT_W+5:0] rhs;
    lhs = {6'h00, a} * (CNT_W+6)'(den);
    rhs = {6'h00, b} * (CNT_W+6)'(num);
    return lhs >= rhs;
  endfunction

  function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] x);
    return (x == CNT_MAX) ? x : x + 1'b1;
  endfunction

  logic s_line, s_vin, s_green, s_inh, s_xray, s_vlock;

  spl_sync2 #(.W(6)) u_sync (
    .clk(clk),
    .nrst(nrst),
    .d({line_or_composite_input, vsync_in, green_sync_in, line_loop_inhibit_input, xray_in, vert_lock_in}),
    .q({s_line, s_vin, s_green, s_inh, s_xray, s_vlock})
  );

  // Input selection, polarity and pulse analysis.
  logic signed [CNT_W-1:0] hbal_r, hbal_nxt, vbal_r, vbal_nxt;
  logic hneg_r, hneg_nxt, vneg_r, vneg_nxt;
  logic n_d_r, line_d_r, vin_d_r, vext_r, vext_nxt;
  logic [CNT_W-1:0] z_cnt_r, z_cnt_nxt, z_last_r, z_last_nxt;
  logic [CNT_W-1:0] t_cnt_r, t_cnt_nxt, a_cnt_r, a_cnt_nxt, per_r, per_nxt;
  logic hsel, n, lead, trail, short_pulse, far_enough, accept, wide, lost, stale;

  always_comb
  begin
    case (sync_priority)
      PRIO_GREEN: hsel = s_green;
      default: hsel = s_line;
    endcase
    hbal_nxt = bal_step(hbal_r, hsel);
    vbal_nxt = bal_step(vbal_r, s_vin);
    // A line idling high carries low-going pulses, so mostly-high means negative.
    hneg_nxt = hbal_r > 0;
    vneg_nxt = vbal_r > 0;
    n = hsel ^ hneg_r;
    lead = n && !n_d_r;
    trail = !n && n_d_r;
    short_pulse = !ge_frac(z_last_r, t_cnt_r, H_DUTY_NUM, H_DUTY_DEN);
    far_enough = (per_r == '0) || ge_frac(a_cnt_r, per_r, EQ_GAP_NUM, EQ_GAP_DEN);
    accept = lead && short_pulse && far_enough;
    lost = a_cnt_r == CNT_MAX;
    z_cnt_nxt = lead ? CNT_W'(1) : (n ? sat_inc(z_cnt_r) : z_cnt_r);
    z_last_nxt = trail ? z_cnt_r : z_last_r;
    t_cnt_nxt = lead ? CNT_W'(1) : sat_inc(t_cnt_r);
    a_cnt_nxt = accept ? CNT_W'(1) : sat_inc(a_cnt_r);
    // After missed pulses the period is learnt afresh, or the gap filter would lock onto a fraction of the rate.
    stale = (per_r != '0) && ge_frac(a_cnt_r, per_r, MISS_NUM, MISS_DEN);
    per_nxt = lost ? '0 : (accept ? (stale ? '0 : a_cnt_r) : per_r);
    // Serrated vertical pulses stay wide, so the flag holds until a short pulse returns or sync is lost.
    wide = n && (per_r != '0) && ge_frac(z_cnt_r, per_r, VEXT_NUM, VEXT_DEN);
    vext_nxt = wide || (vext_r && !(lead && short_pulse) && !lost);
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      hbal_r <= '0;
      vbal_r <= '0;
      hneg_r <= 1'b0;
      vneg_r <= 1'b0;
      n_d_r <= 1'b0;
      line_d_r <= 1'b0;
      vin_d_r <= 1'b0;
      z_cnt_r <= '0;
      z_last_r <= '0;
      t_cnt_r <= '0;
      // Reset counts as lost sync, so the lock level cannot climb before the first line edge.
      a_cnt_r <= CNT_MAX;
      per_r <= '0;
      vext_r <= 1'b0;
    end
    else
    begin
      hbal_r <= hbal_nxt;
      vbal_r <= vbal_nxt;
      hneg_r <= hneg_nxt;
      vneg_r <= vneg_nxt;
      n_d_r <= n;
      line_d_r <= s_line;
      vin_d_r <= s_vin;
      z_cnt_r <= z_cnt_nxt;
      z_last_r <= z_last_nxt;
      t_cnt_r <= t_cnt_nxt;
      a_cnt_r <= a_cnt_nxt;
      per_r <= per_nxt;
      vext_r <= vext_nxt;
    end
  end

  // Phase activity, filtered level and lock state.
  logic err_r, err_nxt;
  logic [7:0] lvl_r, lvl_nxt;
  spl_lock_t lock_r, lock_nxt;

  always_comb
  begin
    // Activity runs from the first of the two edges to the second, as in a phase-frequency comparator.
    err_nxt = err_r ? !(accept || phase_ref_pulse) : (accept ^ phase_ref_pulse);
    if (err_r || lost)
      lvl_nxt = (lvl_r > LVL_STEP_DN) ? lvl_r - LVL_STEP_DN : 8'h00;
    else
      lvl_nxt = (lvl_r == 8'hff) ? lvl_r : lvl_r + 8'h01;
    lock_nxt = lock_r;
    case (lock_r)
      LK_UNLOCKED: if (lvl_r >= LOCK_HI) lock_nxt = LK_LOCKED;
      LK_LOCKED: if (lvl_r <= LOCK_LO) lock_nxt = LK_UNLOCKED;
      default: lock_nxt = LK_UNLOCKED;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      err_r <= 1'b0;
      lvl_r <= LVL_RST;
      lock_r <= LK_UNLOCKED;
    end
    else
    begin
      err_r <= err_nxt;
      lvl_r <= lvl_nxt;
      lock_r <= lock_nxt;
    end
  end

  // Latches, detection flags, settings and registered outputs.
  logic xray_r, xray_nxt, hdet_r, hdet_nxt, vdet_r, vdet_nxt, vxdet_r, vxdet_nxt;
  logic line_sync_nxt, vsync_nxt, lock_n_nxt, pump_conn_nxt, pump_hi_nxt;
  logic [1:0] force_nxt;
  logic [FREE_W-1:0] free_nxt;
  logic [PHASE_W-1:0] phase_nxt;
  logic [7:0] status_nxt;

  always_comb
  begin
    // A trip in the same cycle as the reset command keeps the latch set.
    xray_nxt = s_xray || (xray_r && !xray_reset);
    // Sets win over a refresh that lands in the same cycle.
    hdet_nxt = (s_line && !line_d_r) || (hdet_r && !det_refresh);
    vdet_nxt = (s_vin && !vin_d_r) || (vdet_r && !det_refresh);
    vxdet_nxt = vext_r || (vxdet_r && !det_refresh);
    force_nxt = (force_mode == FORCE_2X || force_mode == FORCE_3X) ? force_mode : FORCE_NONE;
    pump_conn_nxt = !(vext_r || s_inh || force_nxt != FORCE_NONE);
    pump_hi_nxt = lock_r == LK_LOCKED;
    lock_n_nxt = lock_r != LK_LOCKED;
    free_nxt = free_run_wr ? free_run_code : free_run_frequency;
    phase_nxt = phase_wr ? phase_code : phase_shift;
    line_sync_nxt = (sync_priority == PRIO_GREEN) ? !n : hsel;
    vsync_nxt = (sync_priority == PRIO_SEPARATE) ? s_vin : (vext_r ^ hneg_r);
    status_nxt[ST_HLOCK] = lock_r != LK_LOCKED;
    status_nxt[ST_VLOCK] = !s_vlock;
    status_nxt[ST_XRAY] = xray_r;
    status_nxt[ST_HPOL] = hneg_r;
    status_nxt[ST_VPOL] = vneg_r;
    status_nxt[ST_VEXT] = vxdet_r;
    status_nxt[ST_HDET] = hdet_r;
    status_nxt[ST_VDET] = vdet_r;
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      xray_r <= 1'b0;
      hdet_r <= 1'b0;
      vdet_r <= 1'b0;
      vxdet_r <= 1'b0;
      line_sync_out <= 1'b0;
      vsync_out <= 1'b0;
      line_lock_n_out <= 1'b1;
      internal_line_pulse <= 1'b0;
      pump_connect <= 1'b0;
      pump_high_current <= 1'b0;
      filter_force <= FORCE_NONE;
      free_run_frequency <= FREE_RUN_RST;
      phase_shift <= PHASE_RST;
      status_byte <= STATUS_RST;
    end
    else
    begin
      xray_r <= xray_nxt;
      hdet_r <= hdet_nxt;
      vdet_r <= vdet_nxt;
      vxdet_r <= vxdet_nxt;
      line_sync_out <= line_sync_nxt;
      vsync_out <= vsync_nxt;
      line_lock_n_out <= lock_n_nxt;
      internal_line_pulse <= accept;
      pump_connect <= pump_conn_nxt;
      pump_high_current <= pump_hi_nxt;
      filter_force <= force_nxt;
      free_run_frequency <= free_nxt;
      phase_shift <= phase_nxt;
      status_byte <= status_nxt;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  a_lock_pin_level: assert property (##1 line_lock_n_out == ($past(lock_r) != LK_LOCKED))
    else $error("lock pin disagrees with lock state");
  a_pump_current: assert property (lock_r == LK_LOCKED |=> pump_high_current && !line_lock_n_out)
    else $error("pump current low while locked");
  a_lock_hyst: assert property (lock_r == LK_UNLOCKED && lvl_r < LOCK_HI |=> lock_r == LK_UNLOCKED)
    else $error("lock declared below upper threshold");
  a_unlock_hyst: assert property (lock_r == LK_LOCKED && lvl_r > LOCK_LO |=> lock_r == LK_LOCKED)
    else $error("unlock declared above lower threshold");
  a_xray_sticky: assert property (xray_r && !xray_reset |=> xray_r ##1 status_byte[ST_XRAY])
    else $error("x-ray latch lost without reset command");
  a_xray_trip: assert property (s_xray |=> xray_r)
    else $error("x-ray trip not latched");
  a_vext_inhibit: assert property (vext_r |=> !pump_connect)
    else $error("pump connected during extracted vertical");
  a_ext_inhibit: assert property (s_inh |=> !pump_connect)
    else $error("pump connected while inhibit input high");
  a_force_hold: assert property (force_mode == FORCE_3X |=> !pump_connect && filter_force == FORCE_3X)
    else $error("forced frequency does not hold the filter");
  a_refresh_clear: assert property (det_refresh && !(s_line && !line_d_r) |=> !hdet_r)
    else $error("line detection flag survived refresh");
  a_free_run_rst: assert property (!$past(nrst) |-> free_run_frequency == FREE_RUN_RST)
    else $error("free-run setting wrong after reset");
  a_green_out: assert property (sync_priority == PRIO_GREEN |=> line_sync_out == !$past(n))
    else $error("green-mode line output not negative");
  a_line_gap: assert property (accept && per_r != '0 |-> 4 * a_cnt_r >= 3 * per_r)
    else $error("line pulse accepted too soon after previous");

  c_lock: cover property (lock_r == LK_UNLOCKED ##1 lock_r == LK_LOCKED);
  c_vext: cover property (!vext_r ##1 vext_r);
  c_xray: cover property (xray_r ##1 xray_reset ##1 !xray_r);
  c_force: cover property (force_mode == FORCE_2X ##1 filter_force == FORCE_2X);

endmodule

// ---- dv/spl_sync_src.sv ----
// Behavioural sync source that drives the line or composite sync pin.
// Assumes the bench sets period and width in system clock cycles.
module spl_sync_src (
  input wire logic clk,
  input wire logic run,
  input wire logic neg,
  input wire logic eq,
  input wire logic [15:0] period,
  input wire logic [15:0] width,
  output logic line
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] cnt_r;
  logic act;
  always_ff @(posedge clk)
  begin
    cnt_r <= (!run || cnt_r == period - 16'h1) ? 16'h0 : cnt_r + 16'h1;
  end
  // An equalizing pulse sits at mid-line so that the device has to drop it.
  always_comb
  begin
    act = run && (cnt_r < width || (eq && cnt_r >= period / 2 && cnt_r < period / 2 + 16'h2));
    line = act ^ neg;
  end
endmodule

// ---- dv/tb.sv ----
// Self-checking bench for the sync processor and line-lock supervisor.
// Assumes a shortened lost-sync timeout of 2^12 cycles.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import spl_pkg::*;
  logic clk, nrst, line_in, vsync_in, inhib, xray_in, vlock_in, phase_ref_pulse, det_refresh, xray_reset;
  logic free_run_wr, phase_wr, run, neg, eq, green_in;
  logic [1:0] sync_priority, force_mode;
  logic [4:0] free_run_code, phase_code;
  logic [15:0] width;
  logic line_sync_out, vsync_out, line_lock_n_out, internal_line_pulse, pump_connect, pump_high_current;
  logic [1:0] filter_force;
  logic [4:0] free_run_frequency, phase_shift;
  logic [7:0] status_byte;
  int err_total = 0;
  int cmp_count = 0;
  int n;
  spl_sync_src i_src (.clk(clk), .run(run), .neg(neg), .eq(eq), .period(16'h64), .width(width), .line(line_in));
  spl_top #(.CNT_W(12)) i_dut (.clk(clk), .nrst(nrst), .line_or_composite_input(line_in), .vsync_in(vsync_in),
    .green_sync_in(green_in), .line_loop_inhibit_input(inhib), .xray_in(xray_in), .vert_lock_in(vlock_in),
    .phase_ref_pulse(phase_ref_pulse), .sync_priority(sync_priority), .det_refresh(det_refresh),
    .xray_reset(xray_reset), .force_mode(force_mode), .free_run_wr(free_run_wr), .free_run_code(free_run_code),
    .phase_wr(phase_wr), .phase_code(phase_code), .line_sync_out(line_sync_out), .vsync_out(vsync_out),
    .line_lock_n_out(line_lock_n_out), .internal_line_pulse(internal_line_pulse), .pump_connect(pump_connect),
    .pump_high_current(pump_high_current), .filter_force(filter_force), .free_run_frequency(free_run_frequency),
    .phase_shift(phase_shift), .status_byte(status_byte));
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // The oscillator phase reference trails each accepted edge, as a locked loop would.
  always @(posedge clk) phase_ref_pulse <= internal_line_pulse;
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e)
    begin
      err_total++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic refresh;
    @(posedge clk) det_refresh <= 1'b1;
    @(posedge clk) det_refresh <= 1'b0;
  endtask
  task automatic count_lines(output int c);
    c = 0;
    repeat (1000)
    begin
      @(posedge clk);
      if (internal_line_pulse === 1'b1) c++;
    end
  endtask
  task automatic end_sim;
    $display("errors %0d compares %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    cyc(60000);
    err_total++;
    end_sim();
  end
  initial
  begin
    {nrst, vsync_in, inhib, xray_in, vlock_in, det_refresh, xray_reset, free_run_wr, phase_wr, run, neg, eq} = '0;
    green_in = 1'b0;
    {sync_priority, force_mode, free_run_code, phase_code} = '0;
    width = 16'ha;
    cyc(8);
    nrst <= 1'b1;
    cyc(2);
    chk("lock_n", 8'h1, 8'(line_lock_n_out));
    chk("free_run", 8'h1f, 8'(free_run_frequency));
    chk("phase", 8'h10, 8'(phase_shift));
    chk("status", 8'hc0, status_byte);
    chk("line_green", 8'h1, 8'(line_sync_out));
    @(posedge clk) {free_run_wr, free_run_code} <= {1'b1, 5'h05};
    @(posedge clk) {free_run_wr, phase_wr, phase_code} <= {1'b0, 1'b1, 5'h00};
    @(posedge clk) phase_code <= 5'h1f;
    @(negedge clk);
    chk("free_run", 8'h05, 8'(free_run_frequency));
    chk("phase", 8'h00, 8'(phase_shift));
    @(posedge clk) phase_wr <= 1'b0;
    @(negedge clk);
    chk("phase", 8'h1f, 8'(phase_shift));
    for (int m = 1; m < 4; m++)
    begin
      @(posedge clk) force_mode <= 2'(m);
      cyc(2);
      chk("filter_force", (m == 3) ? 8'h0 : 8'(m), 8'(filter_force));
      if (m < 3) chk("pump_forced", 8'h0, 8'(pump_connect));
    end
    @(posedge clk) {force_mode, xray_in, vlock_in, green_in} <= {2'h0, 1'b1, 1'b1, 1'b1};
    cyc(4);
    chk("line_green_pulse", 8'h0, 8'(line_sync_out));
    {xray_in, green_in} <= 2'b00;
    cyc(30);
    chk("xray_held", 8'h1, 8'(status_byte[ST_XRAY]));
    chk("vlock", 8'h0, 8'(status_byte[ST_VLOCK]));
    @(posedge clk) xray_reset <= 1'b1;
    @(posedge clk) xray_reset <= 1'b0;
    cyc(3);
    chk("xray_clr", 8'h0, 8'(status_byte[ST_XRAY]));
    sync_priority <= PRIO_SEPARATE;
    refresh();
    run <= 1'b1;
    cyc(4000);
    chk("hlock", 8'h0, 8'(status_byte[ST_HLOCK]));
    chk("lock_n", 8'h0, 8'(line_lock_n_out));
    chk("pump_hi", 8'h1, 8'(pump_high_current));
    chk("det", 8'h2, 8'(status_byte[2:0]));
    chk("hpol", 8'h0, 8'(status_byte[ST_HPOL]));
    count_lines(n);
    chk("lines", 8'd10, 8'(n));
    eq <= 1'b1;
    cyc(200);
    count_lines(n);
    chk("lines_eq", 8'd10, 8'(n));
    @(posedge clk) {eq, vsync_in} <= {1'b0, 1'b1};
    cyc(6);
    chk("vsync_out", 8'h1, 8'(vsync_out));
    chk("vdet", 8'h1, 8'(status_byte[ST_VDET]));
    @(posedge clk) {vsync_in, inhib} <= {1'b0, 1'b1};
    cyc(6);
    chk("vsync_out", 8'h0, 8'(vsync_out));
    chk("pump_inhib", 8'h0, 8'(pump_connect));
    inhib <= 1'b0;
    cyc(6);
    chk("pump_conn", 8'h1, 8'(pump_connect));
    neg <= 1'b1;
    cyc(6000);
    chk("hpol", 8'h1, 8'(status_byte[ST_HPOL]));
    count_lines(n);
    chk("lines_neg", 8'd10, 8'(n));
    {neg, sync_priority} <= {1'b0, PRIO_COMPOSITE};
    // The balance counter needs about 26 lines to swing back to positive polarity.
    cyc(3500);
    refresh();
    cyc(3);
    chk("vext_clr", 8'h0, 8'(status_byte[ST_VEXT]));
    width <= 16'h32;
    cyc(350);
    chk("pump_vext", 8'h0, 8'(pump_connect));
    chk("vext", 8'h1, 8'(status_byte[ST_VEXT]));
    chk("vsync_vext", 8'h1, 8'(vsync_out));
    {width, run} <= {16'ha, 1'b0};
    // The extracted vertical flag only drops once the line is declared lost.
    cyc(4500);
    refresh();
    cyc(3);
    chk("det_clr", 8'h0, 8'(status_byte[2:0]));
    chk("lock_n_lost", 8'h1, 8'(line_lock_n_out));
    end_sim();
  end
endmodule
